//--- bench/rs_pin_model.sv
// Board side of the reset pin: pull-up and an external reset switch
`timescale 1ns/10ps
module rs_pin_model (
	input wire logic pinOe, // Device drives the pin
	input wire logic pinOut, // Value the device drives
	input wire logic extLow, // Board switch pulls low
	output logic pinLevel // Level on the wire
);
	// ****************************************
	// Open-drain wire
	// ****************************************
	// Any party pulling low wins; the pull-up restores high once all let go
	assign pinLevel = ((pinOe && !pinOut) || extLow) ? 1'b0 : 1'b1;
endmodule : rs_pin_model

//--- bench/rs_reset_sequencer_sva.sv
// Port assertions for the reset sequencer
`timescale 1ns/10ps
module rs_reset_sequencer_sva (
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Reset, low
	input wire logic illegal_op, // Source
	input wire logic low_voltage, // Source
	input wire logic power_up_pulse, // Source
	input wire logic break_active, // Break
	input wire logic rst_pin_in, // Pin level
	input wire logic rst_pin_hv, // Test voltage
	input wire logic irq_pin_1_hv, // Test voltage
	input wire logic rst_pin_out, // Pin value
	input wire logic rst_pin_oe, // Pin drive
	input wire logic core_reset, // Core reset
	input wire logic bus_clk_en, // Bus clocks
	input wire logic wd_disabled // Watchdog off
);
	// ****************************************
	// Helper and properties
	// ****************************************
	logic [12:0] stabCnt_reg;
	// Cycles spent with bus clocks off since they last ran
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) stabCnt_reg <= 13'h0000;
		else if (bus_clk_en) stabCnt_reg <= 13'h0000;
		else stabCnt_reg <= stabCnt_reg + 13'h0001;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_drive_level:
		assert property (rst_pin_oe |-> !rst_pin_out) else $error("pin driven high");
	a_drive_core:
		assert property (rst_pin_oe |-> core_reset) else $error("pin drive without core reset");
	a_illegal_op_flag_start:
		assert property (illegal_op && !core_reset |=> core_reset && rst_pin_oe)
		else $error("illegal opcode ignored");
	a_drive_len:
		assert property ($rose(rst_pin_oe) && !$past(low_voltage) && !$past(power_up_pulse)
			|-> ##31 rst_pin_oe ##1 !rst_pin_oe) else $error("pin drive length wrong");
	a_hold_len:
		assert property ($fell(rst_pin_oe) |-> ##31 core_reset ##1 !core_reset)
		else $error("core reset hold wrong");
	a_ext_pin:
		assert property (!rst_pin_in && !core_reset |-> ##[1:4] core_reset)
		else $error("pin low not taken");
	a_stab_time:
		assert property ($rose(bus_clk_en) && core_reset |-> stabCnt_reg inside
			{[13'h0FFF:13'h1001]}) else $error("bus clocks start off time");
	a_wd_on:
		assert property ((!rst_pin_hv && !irq_pin_1_hv) [*4] |-> !wd_disabled)
		else $error("watchdog off without test voltage");
	a_wd_brk:
		assert property ((break_active && rst_pin_hv) [*5] |-> wd_disabled)
		else $error("watchdog on in break with test voltage");
endmodule : rs_reset_sequencer_sva
bind rs_reset_sequencer rs_reset_sequencer_sva i_sva (.ref_clk, .rst_n, .illegal_op,
	.low_voltage, .power_up_pulse, .break_active, .rst_pin_in, .rst_pin_hv, .irq_pin_1_hv,
	.rst_pin_out, .rst_pin_oe, .core_reset, .bus_clk_en, .wd_disabled);

//--- bench/tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
module tb_top;
	// ****************************************
	// Signals and helpers
	// ****************************************
	typedef struct packed {logic [31:0] m; logic [31:0] d; logic e;} rs_exp_t;
	logic ref_clk, rst_n, power_up_pulse, low_voltage, illegal_op, stop_instr, opcode_fetch;
	logic unmapped_addr, wake_event, break_active, rst_pin_hv, irq_pin_1_hv, usb_dp, usb_dm;
	logic psel, penable, pwrite, pull, pinLevel;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic rst_pin_out, rst_pin_oe, core_reset, clock_gen_out_en, bus_clk_en, usb_irq;
	logic usb_unaddressed, wd_disabled, pready, pslverr;
	logic [15:0] reset_vector;
	rs_exp_t expQ[$];
	rs_exp_t expNow;
	int checks, mismatches, seed, irqCnt, irqBase;
	int pinLen[2] = '{40, 80};
	rs_pin_model i_pin (.pinOe(rst_pin_oe), .pinOut(rst_pin_out), .extLow(pull), .pinLevel);
	rs_reset_sequencer i_dut (.ref_clk, .rst_n, .power_up_pulse, .low_voltage, .illegal_op,
		.stop_instr, .opcode_fetch, .unmapped_addr, .wake_event, .break_active,
		.rst_pin_in(pinLevel), .rst_pin_out, .rst_pin_oe, .rst_pin_hv, .irq_pin_1_hv, .usb_dp,
		.usb_dm, .core_reset, .clock_gen_out_en, .bus_clk_en, .reset_vector, .usb_irq,
		.usb_unaddressed, .wd_disabled, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic waitRun;
		int n;
		n = 0;
		while (core_reset !== 1'b0) begin
			@(posedge ref_clk);
			n++;
			if (n > 6000) begin
				mismatches++;
				summarize();
			end
		end
	endtask : waitRun
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		input logic [31:0] m, input logic [31:0] d, input logic e);
		int n;
		expQ.push_back({m, d, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] m, d, input logic e);
		apb(1'b0, a, 32'h0, m, d, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, 32'h0, 32'h0, 1'b0);
	endtask : wr
	// Writes carry a zero mask, so only the error flag is compared for them
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1) begin
			expNow = expQ.pop_front();
			check({pslverr, prdata & expNow.m}, {expNow.e, expNow.d});
		end
		if (usb_irq === 1'b1) irqCnt++;
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst_n, power_up_pulse, low_voltage, illegal_op, stop_instr, opcode_fetch} = 6'h00;
		{unmapped_addr, wake_event, break_active, rst_pin_hv, irq_pin_1_hv, usb_dm} = 6'h00;
		{psel, penable, pwrite, pull, usb_dp} = 5'h01;
		paddr = 8'h00;
		pwdata = 32'h0;
		seed = 32'h50D3;
		tick(8);
		rst_n <= 1'b1;
		tick(100);
		check(33'({rst_pin_oe, bus_clk_en, clock_gen_out_en, core_reset}), 33'hB);
		waitRun();
		check(33'({bus_clk_en, reset_vector}), 33'h1FFFE);
		rd(8'h00, 32'h7F, 32'h01, 1'b0);
		rd(8'h00, 32'h7F, 32'h00, 1'b0);
		rd(8'h04, 32'hF, 32'h2, 1'b0);
		rd(8'h14, 32'hFFFFFFFF, 32'h0, 1'b1);
		rd(8'h08, 32'hFFFFFFFF, 32'h0, 1'b0);
		$display("test power-on done");
		unmapped_addr <= 1'b1;
		tick(1);
		unmapped_addr <= 1'b0;
		tick(4);
		check(33'(core_reset), 33'h0);
		for (int i = 0; i < 3; i++) begin
			if (i == 2) wr(8'h04, 32'h0);
			illegal_op <= (i == 0);
			{opcode_fetch, unmapped_addr} <= {2{i == 1}};
			stop_instr <= (i == 2);
			tick(1);
			{illegal_op, opcode_fetch, unmapped_addr, stop_instr} <= 4'h0;
			tick(3);
			waitRun();
			rd(8'h00, 32'h7F, (i == 1) ? 32'h10 : 32'h08, 1'b0);
			rd(8'h0C, 32'h1F00, 32'h0, 1'b0);
		end
		$display("test internal resets done");
		wr(8'h04, 32'h3);
		stop_instr <= 1'b1;
		tick(1);
		stop_instr <= 1'b0;
		tick(4);
		check(33'({core_reset, bus_clk_en}), 33'h0);
		wake_event <= 1'b1;
		tick(1);
		wake_event <= 1'b0;
		tick(30);
		check(33'(bus_clk_en), 33'h0);
		tick(3);
		check(33'(bus_clk_en), 33'h1);
		$display("test stop recovery done");
		foreach (pinLen[i]) begin
			pull <= 1'b1;
			tick(pinLen[i]);
			pull <= 1'b0;
			tick(4);
			waitRun();
			rd(8'h00, 32'h7F, (pinLen[i] >= 67) ? 32'h02 : 32'h00, 1'b0);
		end
		wr(8'h08, $random(seed));
		rd(8'h0C, 32'h7E1FC0, 32'h0, 1'b0);
		{break_active, rst_pin_hv} <= 2'h3;
		tick(6);
		check(33'(wd_disabled), 33'h1);
		{break_active, rst_pin_hv} <= 2'h0;
		tick(6);
		check(33'(wd_disabled), 33'h0);
		wr(8'h04, 32'hA);
		irq_pin_1_hv <= 1'b1;
		tick(6);
		check(33'({wd_disabled, reset_vector}), 33'h1FEFE);
		irq_pin_1_hv <= 1'b0;
		$display("test pin and watchdog done");
		for (int i = 0; i < 4; i++) begin
			irqBase = irqCnt;
			wr(8'h04, (i == 2) ? 32'h6 : 32'h2);
			wr(8'h10, (i == 3) ? 32'h0 : 32'h80);
			usb_dp <= 1'b0;
			tick((i == 0) ? 50 : 80);
			usb_dp <= 1'b1;
			tick(4);
			check(33'(core_reset), 33'(i == 1));
			check(33'(irqCnt - irqBase), 33'(i == 2));
			check(33'(usb_unaddressed), 33'(i == 1 || i == 2));
			waitRun();
			rd(8'h00, 32'h7F, (i == 1) ? 32'h40 : 32'h00, 1'b0);
		end
		$display("test usb done");
		for (int i = 0; i < 2; i++) begin
			illegal_op <= (i == 1);
			tick(1);
			illegal_op <= 1'b0;
			tick(3);
			waitRun();
			{low_voltage, power_up_pulse} <= {i == 0, i == 1};
			tick(1);
			{low_voltage, power_up_pulse} <= 2'h0;
			tick(100);
			check(33'({rst_pin_oe, bus_clk_en, core_reset}), 33'h5);
			waitRun();
			rd(8'h00, 32'h7F, (i == 0) ? 32'h20 : 32'h01, 1'b0);
		end
		tick(4100);
		rd(8'h0C, 32'h7E0000, 32'h20000, 1'b0);
		wr(8'h08, $random(seed));
		rd(8'h0C, 32'h7E1FC0, 32'h0, 1'b0);
		$display("test long resets and watchdog done");
		summarize();
	end
endmodule : tb_top

//--- common/rs_params.svh
// Constants for the reset sequencer: offsets, field positions, reset values, counts
`ifndef RS_PARAMS_SVH
`define RS_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define RS_OFF_CAUSE 8'h00
`define RS_OFF_CTRL 8'h04
`define RS_OFF_KICK 8'h08
`define RS_OFF_STAT 8'h0C
`define RS_OFF_USB 8'h10

// ****************************************
// Reset cause bit positions
// ****************************************
`define RS_C_POR 0
`define RS_C_PIN 1
`define RS_C_WD 2
`define RS_C_ILLEGAL_OP_FLAG 3
`define RS_C_ILLEGAL_ADDR_FLAG 4
`define RS_C_LVI 5
`define RS_C_USB 6

// ****************************************
// Control bit positions and reset values
// ****************************************
`define RS_CT_SSR 0
`define RS_CT_STOPEN 1
`define RS_CT_USBIRQ 2
`define RS_CT_MON 3
`define RS_CTRL_RST 4'h2
`define RS_USB_EN 7
`define RS_CAUSE_RST 7'h01

// ****************************************
// Timing counts in osc_clk cycles, the watchdog limit in prescaled ticks, with the SE0 time and clock period in ns
// ****************************************
`define RS_STAB_CYC 13'h1000
`define RS_DRIVE_CYC 13'h0020
`define RS_HOLD_CYC 13'h0020
`define RS_SHORT_REC 13'h0020
`define RS_PIN_MIN 13'h0043
`define RS_PIN_MIN_POR 13'h1043
`define RS_WD_MAX 6'h3F
`define RS_SE0_NS 2500
`define RS_CLK_NS 40
`define RS_SE0_CYC ((`RS_SE0_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)

// ****************************************
// Reset vectors
// ****************************************
`define RS_VEC_USER 16'hFFFE
`define RS_VEC_MON 16'hFEFE

`endif

//--- common/rs_pkg.sv
// Types of the reset sequencer
package rs_pkg;

	typedef enum logic [2:0] {
		RS_RUN,
		RS_STAB,
		RS_DRIVE,
		RS_HOLD,
		RS_EXTHOLD,
		RS_STOPPED,
		RS_RECOVER
	} rs_state_t;

	typedef struct packed {
		rs_state_t st;
		logic [12:0] simCnt;
		logic [12:0] phCnt;
		logic [12:0] pinLowCnt;
		logic porCtx;
		logic [5:0] wdCnt;
		logic [6:0] cause;
		logic [3:0] ctrl;
		logic usb_enable;
		logic [6:0] usbAddr;
		logic usbUnaddr;
		logic [6:0] se0Cnt;
		logic se0Hit;
		logic [4:0] s1;
		logic [4:0] s2;
		logic coreReset;
		logic pinOe;
		logic busClkEn;
		logic clkGenEn;
		logic usbIrq;
		logic wdOff;
		logic [15:0] vector;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rs_regs_t;

endpackage : rs_pkg

//--- core/rs_reset_sequencer.sv
// Reset sequencer: reset sources, reset pin drive, cause flags, 13-bit stabilization counter
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "rs_params.svh"

module rs_reset_sequencer
	import rs_pkg::*;
(
	input wire logic ref_clk, // osc_clk, 25 MHz
	input wire logic rst_n, // Asynchronous power-on reset, low
	input wire logic power_up_pulse, // Power-on pulse from supply monitor
	input wire logic low_voltage, // Low-voltage trip
	input wire logic illegal_op, // Illegal opcode decoded
	input wire logic stop_instr, // Stop instruction executed
	input wire logic opcode_fetch, // Current access is an opcode fetch
	input wire logic unmapped_addr, // Current access hits no memory
	input wire logic wake_event, // Interrupt or break ending stop
	input wire logic break_active, // Break state
	input wire logic rst_pin_in, // Reset pin level
	output logic rst_pin_out, // Reset pin output value, always low
	output logic rst_pin_oe, // Reset pin drive enable
	input wire logic rst_pin_hv, // Test high voltage on reset pin
	input wire logic irq_pin_1_hv, // Test high voltage on irq_pin_1
	input wire logic usb_dp, // USB D+ input
	input wire logic usb_dm, // USB D- input
	output logic core_reset, // Internal reset, high
	output logic clock_gen_out_en, // Clock generator output enable
	output logic bus_clk_en, // internal_bus_clocks running
	output logic [15:0] reset_vector, // Vector address to fetch
	output logic usb_irq, // USB reset interrupt request, pulse
	output logic usb_unaddressed, // USB attached but unaddressed
	output logic wd_disabled, // Watchdog disabled by test voltage
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr // APB error
);

	rs_regs_t r_reg;
	rs_regs_t r_next;

	// ****************************************
	// Combinational helpers
	// ****************************************
	logic pinLow;
	logic hvPin;
	logic hvIrq;
	logic se0;
	logic inReset;
	logic wdGate;
	logic wdTick;
	logic wdOvf;
	logic access;
	logic setup;
	logic kick;
	logic illegal_op_flag;
	logic illegal_addr_flag;
	logic usbEvt;
	logic porEvt;
	logic lviEvt;
	logic [6:0] setBits;
	logic [31:0] rdVal;
	logic rdHit;

	always_comb begin
		pinLow = ~r_reg.s2[0];
		hvPin = r_reg.s2[1];
		hvIrq = r_reg.s2[2];
		se0 = ~r_reg.s2[3] & ~r_reg.s2[4];
		inReset = (r_reg.st == RS_STAB) || (r_reg.st == RS_DRIVE) ||
			(r_reg.st == RS_HOLD) || (r_reg.st == RS_EXTHOLD);
		// Only a high voltage may turn the watchdog off, so noise cannot
		wdGate = (r_reg.ctrl[`RS_CT_MON] & (hvPin | hvIrq)) |
			(break_active & hvPin);
		wdTick = (r_reg.simCnt == 13'h1FFF);
		setup = psel & ~penable;
		access = psel & penable & r_reg.pready;
		kick = access & pwrite & (paddr == `RS_OFF_KICK);
		wdOvf = wdTick & (r_reg.wdCnt == `RS_WD_MAX) & ~wdGate & ~kick &
			~inReset;
		illegal_op_flag = ~inReset & (illegal_op |
			(stop_instr & ~r_reg.ctrl[`RS_CT_STOPEN]));
		illegal_addr_flag = ~inReset & opcode_fetch & unmapped_addr;
		usbEvt = r_reg.usb_enable & (r_reg.se0Cnt == 7'(`RS_SE0_CYC)) &
			~r_reg.se0Hit;
		porEvt = power_up_pulse;
		lviEvt = low_voltage;
		setBits = '0;
		setBits[`RS_C_POR] = porEvt;
		setBits[`RS_C_LVI] = lviEvt;
		setBits[`RS_C_WD] = wdOvf;
		setBits[`RS_C_ILLEGAL_OP_FLAG] = illegal_op_flag;
		setBits[`RS_C_ILLEGAL_ADDR_FLAG] = illegal_addr_flag;
		setBits[`RS_C_USB] = usbEvt & ~r_reg.ctrl[`RS_CT_USBIRQ] & ~inReset;
		setBits[`RS_C_PIN] = r_reg.pinLowCnt == (r_reg.porCtx ? `RS_PIN_MIN_POR
			: `RS_PIN_MIN);

		rdHit = 1'b1;
		rdVal = '0;
		unique case (paddr)
			`RS_OFF_CAUSE: rdVal[6:0] = r_reg.cause;
			`RS_OFF_CTRL: rdVal[3:0] = r_reg.ctrl;
			`RS_OFF_KICK: rdVal = '0;
			`RS_OFF_STAT: rdVal = {9'h000, r_reg.wdCnt, 1'b0, r_reg.st,
				r_reg.simCnt};
			`RS_OFF_USB: rdVal[7:0] = {r_reg.usb_enable, r_reg.usbAddr};
			default: rdHit = 1'b0;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.s1 = {usb_dm, usb_dp, irq_pin_1_hv, rst_pin_hv, rst_pin_in};
		r_next.s2 = r_reg.s1;
		r_next.usbIrq = 1'b0;
		r_next.simCnt = r_reg.simCnt + 13'h0001;
		r_next.phCnt = r_reg.phCnt + 13'h0001;

		// Watchdog prescaled by the counter overflow
		if (wdTick && !wdGate) begin
			r_next.wdCnt = r_reg.wdCnt + 6'h01;
		end
		if (kick) begin
			r_next.wdCnt = '0;
			r_next.simCnt[12:5] = 8'h00;
		end
		if (wdGate) begin
			r_next.wdCnt = '0;
		end

		// Pin low time; saturates so a long hold never retriggers the flag
		if (pinLow) begin
			if (r_reg.pinLowCnt != 13'h1FFF) begin
				r_next.pinLowCnt = r_reg.pinLowCnt + 13'h0001;
			end
		end else begin
			r_next.pinLowCnt = '0;
		end

		// SE0 duration
		if (se0 && r_reg.usb_enable) begin
			if (r_reg.se0Cnt != 7'(`RS_SE0_CYC)) begin
				r_next.se0Cnt = r_reg.se0Cnt + 7'h01;
			end
		end else begin
			r_next.se0Cnt = '0;
		end
		if (usbEvt) begin
			r_next.se0Hit = 1'b1;
			r_next.usbAddr = '0;
		end
		if (r_reg.se0Hit && !se0) begin
			r_next.se0Hit = 1'b0;
			r_next.usbUnaddr = 1'b1;
		end

		// APB side
		r_next.pready = setup;
		r_next.pslverr = setup & ~rdHit;
		r_next.prdata = setup ? rdVal : '0;
		if (access && !pwrite && paddr == `RS_OFF_CAUSE) begin
			r_next.cause = '0;
		end
		if (access && pwrite && paddr == `RS_OFF_CTRL) begin
			r_next.ctrl = pwdata[3:0];
		end
		if (access && pwrite && paddr == `RS_OFF_USB) begin
			r_next.usb_enable = pwdata[`RS_USB_EN];
			r_next.usbAddr = pwdata[6:0];
			r_next.usbUnaddr = 1'b0;
		end
		// Setting a flag wins over a read clear in the same cycle
		r_next.cause = r_next.cause | setBits;

		// Sequencer
		unique case (r_reg.st)
			RS_RUN: begin
				if (stop_instr && r_reg.ctrl[`RS_CT_STOPEN]) begin
					r_next.st = RS_STOPPED;
					r_next.busClkEn = 1'b0;
					r_next.simCnt = '0;
				end else if (pinLow) begin
					r_next.st = RS_EXTHOLD;
					r_next.coreReset = 1'b1;
				end
			end
			RS_STOPPED: begin
				r_next.simCnt = '0;
				if (wake_event) begin
					r_next.st = RS_RECOVER;
				end else if (pinLow) begin
					r_next.st = RS_EXTHOLD;
					r_next.coreReset = 1'b1;
				end
			end
			RS_RECOVER: begin
				if (r_reg.simCnt == (r_reg.ctrl[`RS_CT_SSR] ? `RS_SHORT_REC
						: `RS_STAB_CYC) - 13'h0001) begin
					r_next.st = RS_RUN;
					r_next.busClkEn = 1'b1;
				end else if (pinLow) begin
					// A pin reset during recovery is taken at once
					r_next.st = RS_EXTHOLD;
					r_next.coreReset = 1'b1;
				end
			end
			RS_STAB: begin
				if (r_reg.phCnt == `RS_STAB_CYC - 13'h0001) begin
					r_next.st = RS_DRIVE;
					r_next.phCnt = '0;
					r_next.busClkEn = 1'b1;
				end
			end
			RS_DRIVE: begin
				if (r_reg.phCnt == `RS_DRIVE_CYC - 13'h0001) begin
					r_next.st = RS_HOLD;
					r_next.phCnt = '0;
					r_next.pinOe = 1'b0;
				end
			end
			RS_HOLD: begin
				if (r_reg.phCnt == `RS_HOLD_CYC - 13'h0001) begin
					r_next.st = RS_RUN;
					r_next.coreReset = 1'b0;
					// Resets taken out of stop would otherwise leave the clocks gated
					r_next.busClkEn = 1'b1;
					r_next.porCtx = 1'b0;
				end
			end
			RS_EXTHOLD: begin
				r_next.phCnt = '0;
				if (!pinLow) begin
					r_next.st = RS_HOLD;
				end
			end
			default: begin
				r_next.st = RS_RUN;
			end
		endcase

		// Internal sources restart the sequence and clear the counter
		if (wdOvf || illegal_op_flag || illegal_addr_flag) begin
			r_next.st = RS_DRIVE;
			r_next.phCnt = '0;
			r_next.simCnt = '0;
			r_next.pinOe = 1'b1;
			r_next.coreReset = 1'b1;
			r_next.wdCnt = '0;
		end
		if (usbEvt && !inReset) begin
			if (r_reg.ctrl[`RS_CT_USBIRQ]) begin
				r_next.usbIrq = 1'b1;
			end else begin
				r_next.st = RS_HOLD;
				r_next.phCnt = '0;
				r_next.simCnt = '0;
				r_next.coreReset = 1'b1;
			end
		end
		if (porEvt || lviEvt) begin
			r_next.st = RS_STAB;
			r_next.phCnt = '0;
			r_next.simCnt = '0;
			r_next.pinOe = 1'b1;
			r_next.coreReset = 1'b1;
			r_next.busClkEn = 1'b0;
			r_next.clkGenEn = 1'b1;
			r_next.porCtx = 1'b1;
			r_next.wdCnt = '0;
		end
		if (porEvt) begin
			r_next.cause = 7'h00;
			r_next.cause[`RS_C_POR] = 1'b1;
		end
		r_next.vector = r_next.ctrl[`RS_CT_MON] ? `RS_VEC_MON : `RS_VEC_USER;
		r_next.wdOff = wdGate;
	end

	// ****************************************
	// State register; reset equals a power-on
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '0;
			r_reg.st <= RS_STAB;
			r_reg.cause <= `RS_CAUSE_RST;
			r_reg.ctrl <= `RS_CTRL_RST;
			r_reg.porCtx <= 1'b1;
			r_reg.coreReset <= 1'b1;
			r_reg.pinOe <= 1'b1;
			r_reg.clkGenEn <= 1'b1;
			r_reg.s1 <= 5'h1F;
			r_reg.s2 <= 5'h1F;
			r_reg.vector <= `RS_VEC_USER;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rst_pin_out = 1'b0;
	assign rst_pin_oe = r_reg.pinOe;
	assign core_reset = r_reg.coreReset;
	assign clock_gen_out_en = r_reg.clkGenEn;
	assign bus_clk_en = r_reg.busClkEn;
	assign reset_vector = r_reg.vector;
	assign usb_irq = r_reg.usbIrq;
	assign usb_unaddressed = r_reg.usbUnaddr;
	assign wd_disabled = r_reg.wdOff;
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;

endmodule : rs_reset_sequencer
